// ---- logic/lrc_pkg.sv ----
package lrc_pkg;
  // register offsets, 8-bit address space
  localparam logic [7:0] LDO_A_VSEL_OFS = 8'h50;
  localparam logic [7:0] LDO_A_CTRL_OFS = 8'h51;
  localparam logic [7:0] LDO_B_VSEL_OFS = 8'h54;
  localparam logic [7:0] LDO_B_CTRL_OFS = 8'h55;
  localparam logic [7:0] LDO_C_VSEL_OFS = 8'h60;
  localparam logic [7:0] LDO_C_CTRL_OFS = 8'h61;
  localparam logic [7:0] LDO_D_VSEL_OFS = 8'h64;
  localparam logic [7:0] LDO_D_CTRL_OFS = 8'h65;
  // interrupt registers
  localparam logic [7:0] IRQ_STATUS_OFS = 8'h68;
  localparam logic [7:0] IRQ_CLEAR_OFS = 8'h69;
  localparam logic [7:0] IRQ_ENABLE_OFS = 8'h6A;
  // control field positions
  localparam int CTRL_ON_BIT = 7;
  localparam int CTRL_DIS_BIT = 6;
  localparam int CTRL_LOW_QUIESCENT_MODE_BIT = 5;
  localparam int CTRL_DLY_LSB = 2;
  localparam int CTRL_FIE_BIT = 1;
  localparam int CTRL_PG_BIT = 0;
  localparam int VSEL_W = 6;
  localparam int DLY_W = 3;
  localparam int NUM_LDO = 4;
  // reset values
  localparam logic [5:0] VSEL_RST = 6'h00;
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [3:0] IRQ_EN_RST = 4'h0;
  // turn-on delay: one step of the delay field
  localparam int DLY_STEP_US = 100;
  localparam int CLK_NS = 100;
  localparam int DLY_STEP_CYC = (DLY_STEP_US * 1000) / CLK_NS;
endpackage : lrc_pkg

// ---- logic/lrc_regs.sv ----
// Strobed register access is this design's own decision.
`timescale 1ns/100ps
`default_nettype none
// How it works
// - voltage register holds 6-bit code in bits 5:0; bits 7:6 read zero.
// - control bit 7 switches the regulator on or off.
// - control bit 6 discharges the output while the regulator is off.
// - control bit 5 selects low quiescent current mode.
// - control bits 4:2 select the turn-on delay before enabling.
// - control bit 1 lets that regulator's faults raise an interrupt.
// - control bit 0 reads power good, one above threshold.
module lrc_regs (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic clk_en,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr_stb,
  input wire logic rd_stb,
  output logic [7:0] rdata,
  input wire logic [3:0] pgood_pin,
  input wire logic [3:0] fault_pin,
  output logic [3:0] ldo_on,
  output logic [3:0] ldo_discharge,
  output logic [3:0] ldo_low_quiescent_mode,
  output logic [23:0] voltage_select_code,
  output logic irq
);

  typedef struct packed {
    logic [3:0][5:0] vsel;
    logic [3:0] en;
    logic [3:0] dis;
    logic [3:0] low_quiescent_mode;
    logic [3:0][2:0] dly;
    logic [3:0] fie;
    logic [3:0][15:0] dcnt;
    logic [3:0] on;
    logic [3:0] disout;
    logic [3:0] pg_s1;
    logic [3:0] pg_s2;
    logic [3:0] ft_s1;
    logic [3:0] ft_s2;
    logic [3:0] ft_d;
    logic [3:0] sts;
    logic [3:0] irq_en;
    logic irq;
    logic [7:0] rdata;
  } lrc_state_s;

  lrc_state_s st_reg;
  lrc_state_s st_next;

  // decode an address into regulator index and kind
  function automatic logic [3:0] lrc_hit(input logic [7:0] a, input logic ctrl);
    logic [3:0] h;
    h = 4'h0;
    h[0] = ctrl ? (a == lrc_pkg::LDO_A_CTRL_OFS) : (a == lrc_pkg::LDO_A_VSEL_OFS);
    h[1] = ctrl ? (a == lrc_pkg::LDO_B_CTRL_OFS) : (a == lrc_pkg::LDO_B_VSEL_OFS);
    h[2] = ctrl ? (a == lrc_pkg::LDO_C_CTRL_OFS) : (a == lrc_pkg::LDO_C_VSEL_OFS);
    h[3] = ctrl ? (a == lrc_pkg::LDO_D_CTRL_OFS) : (a == lrc_pkg::LDO_D_VSEL_OFS);
    return h;
  endfunction : lrc_hit

  logic [3:0] vhit;
  logic [3:0] chit;
  assign vhit = lrc_hit(addr, 1'b0);
  assign chit = lrc_hit(addr, 1'b1);

  // next-state logic
  always_comb
  begin
    logic [3:0] fev;
    logic [3:0] clr;
    st_next = st_reg;
    fev = 4'h0;
    clr = 4'h0;
    st_next.pg_s1 = pgood_pin;
    st_next.pg_s2 = st_reg.pg_s1;
    st_next.ft_s1 = fault_pin;
    st_next.ft_s2 = st_reg.ft_s1;
    st_next.ft_d = st_reg.ft_s2;
    if (wr_stb && addr == lrc_pkg::IRQ_CLEAR_OFS)
    begin
      clr = wdata[3:0];
    end
    if (wr_stb && addr == lrc_pkg::IRQ_ENABLE_OFS)
    begin
      st_next.irq_en = wdata[3:0];
    end
    for (int i = 0; i < lrc_pkg::NUM_LDO; i++)
    begin
      if (wr_stb && vhit[i])
      begin
        st_next.vsel[i] = wdata[5:0];
      end
      if (wr_stb && chit[i])
      begin
        st_next.en[i] = wdata[lrc_pkg::CTRL_ON_BIT];
        st_next.dis[i] = wdata[lrc_pkg::CTRL_DIS_BIT];
        st_next.low_quiescent_mode[i] = wdata[lrc_pkg::CTRL_LOW_QUIESCENT_MODE_BIT];
        st_next.dly[i] = wdata[lrc_pkg::CTRL_DLY_LSB +: lrc_pkg::DLY_W];
        st_next.fie[i] = wdata[lrc_pkg::CTRL_FIE_BIT];
      end
      // turn-on delay counts down cycles, dly steps of DLY_STEP_CYC each, then enables the output
      if (!st_reg.en[i])
      begin
        st_next.on[i] = 1'b0;
        // load from the field being written, so enable and delay may share one write
        st_next.dcnt[i] = 16'(st_next.dly[i]) * 16'(lrc_pkg::DLY_STEP_CYC);
      end
      else if (st_reg.dcnt[i] != 16'h0000)
      begin
        st_next.dcnt[i] = st_reg.dcnt[i] - 16'h0001;
      end
      else
      begin
        st_next.on[i] = 1'b1;
      end
      st_next.disout[i] = st_reg.dis[i] && !st_next.on[i];
      fev[i] = st_reg.ft_s2[i] && !st_reg.ft_d[i] && st_reg.fie[i];
    end
    // set wins over clear
    st_next.sts = (st_reg.sts & ~clr) | fev;
    st_next.irq = |(st_next.sts & st_next.irq_en);
    // read data, valid the cycle after the strobe
    st_next.rdata = 8'h00;
    if (rd_stb)
    begin
      for (int i = 0; i < lrc_pkg::NUM_LDO; i++)
      begin
        if (vhit[i])
        begin
          st_next.rdata = {2'b00, st_reg.vsel[i]};
        end
        if (chit[i])
        begin
          st_next.rdata = {st_reg.en[i], st_reg.dis[i], st_reg.low_quiescent_mode[i], st_reg.dly[i],
                           st_reg.fie[i], st_reg.pg_s2[i]};
        end
      end
      if (addr == lrc_pkg::IRQ_STATUS_OFS)
      begin
        st_next.rdata = {4'h0, st_reg.sts};
      end
      if (addr == lrc_pkg::IRQ_ENABLE_OFS)
      begin
        st_next.rdata = {4'h0, st_reg.irq_en};
      end
    end
  end

  // state register
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      st_reg <= '0;
    end
    else if (clk_en)
    begin
      st_reg <= st_next;
    end
  end

  assign rdata = st_reg.rdata;
  assign ldo_on = st_reg.on;
  assign ldo_discharge = st_reg.disout;
  assign ldo_low_quiescent_mode = st_reg.low_quiescent_mode;
  assign voltage_select_code = st_reg.vsel;
  assign irq = st_reg.irq;

  // read of a control register returns fields and power good
  sequence ctrl_read_s;
    rd_stb && clk_en && (chit == 4'h1);
  endsequence

  property ctrl_read_p;
    @(posedge sys_clk) disable iff (rst)
      ctrl_read_s |=> rdata == {$past(st_reg.en[0]), $past(st_reg.dis[0]),
        $past(st_reg.low_quiescent_mode[0]), $past(st_reg.dly[0]), $past(st_reg.fie[0]),
        $past(st_reg.pg_s2[0])};
  endproperty

  ctrl_read_a: assert property (ctrl_read_p)
    else $error("control read data wrong");

  vsel_rsvd_a: assert property (@(posedge sys_clk) disable iff (rst)
    $past(rd_stb && clk_en && vhit != 4'h0) |-> rdata[7:6] == 2'b00)
    else $error("reserved voltage bits not zero");

  vsel_write_a: assert property (@(posedge sys_clk) disable iff (rst)
    (wr_stb && clk_en && vhit[1]) |=> voltage_select_code[11:6] == $past(wdata[5:0]))
    else $error("voltage code not written");

  off_now_a: assert property (@(posedge sys_clk) disable iff (rst)
    (clk_en && !st_reg.en[2]) |=> !ldo_on[2])
    else $error("regulator still on while disabled");

  zero_delay_a: assert property (@(posedge sys_clk) disable iff (rst)
    (clk_en && wr_stb && chit[0] && wdata[7] && wdata[4:2] == 3'h0 && !st_reg.en[0])
      ##1 (clk_en && !(wr_stb && chit[0])) [*2] |=> ldo_on[0])
    else $error("zero delay did not enable");

  dly_hold_a: assert property (@(posedge sys_clk) disable iff (rst)
    (clk_en && st_reg.en[1] && st_reg.dcnt[1] != 16'h0000 && !st_reg.on[1]) |=> !ldo_on[1])
    else $error("regulator on before delay");

  dis_out_a: assert property (@(posedge sys_clk) disable iff (rst)
    ldo_discharge[1] |-> !ldo_on[1])
    else $error("discharge while on");

  low_quiescent_mode_a: assert property (@(posedge sys_clk) disable iff (rst)
    (clk_en && wr_stb && chit[2]) |=> ldo_low_quiescent_mode[2] == $past(wdata[5]))
    else $error("low quiescent mode not written");

  fault_gate_a: assert property (@(posedge sys_clk) disable iff (rst)
    (clk_en && !st_reg.fie[0] && !st_reg.sts[0]) |=> !st_reg.sts[0])
    else $error("masked fault latched");

  // a write that switches regulator b on from off
  sequence b_turn_on_s;
    clk_en && wr_stb && chit[1] && wdata[lrc_pkg::CTRL_ON_BIT] && !st_reg.en[1];
  endsequence

  // two enabled edges, the depth of the power good synchroniser
  sequence pg_two_edges_s;
    (clk_en && !rst) ##1 clk_en;
  endsequence

  // a fault edge on regulator c while its interrupt is enabled
  sequence c_fault_edge_s;
    clk_en && st_reg.ft_s2[2] && !st_reg.ft_d[2] && st_reg.fie[2];
  endsequence

  // the counter starts from the delay just written, not the old one
  dly_load_a: assert property (@(posedge sys_clk) disable iff (rst)
    b_turn_on_s |=> st_reg.dcnt[1] ==
      16'($past(wdata[lrc_pkg::CTRL_DLY_LSB +: lrc_pkg::DLY_W])) * 16'(lrc_pkg::DLY_STEP_CYC))
    else $error("turn-on delay not loaded from the written field");

  // count exhausted while enabled: output follows
  on_at_zero_a: assert property (@(posedge sys_clk) disable iff (rst)
    (clk_en && st_reg.en[1] && st_reg.dcnt[1] == 16'h0000) |=> ldo_on[1])
    else $error("regulator not on after delay");

  // every writable control field lands
  ctrl_write_a: assert property (@(posedge sys_clk) disable iff (rst)
    (clk_en && wr_stb && chit[1]) |=> {st_reg.en[1], st_reg.dis[1], st_reg.low_quiescent_mode[1],
      st_reg.dly[1], st_reg.fie[1]} == $past(wdata[7:1]))
    else $error("control fields not written");

  // shut down with discharge set: discharge path active
  dis_on_a: assert property (@(posedge sys_clk) disable iff (rst)
    (clk_en && st_reg.dis[0] && !st_reg.en[0]) |=> ldo_discharge[0])
    else $error("no discharge in shutdown");

  // discharge bit clear: never discharge
  dis_none_a: assert property (@(posedge sys_clk) disable iff (rst)
    (clk_en && !st_reg.dis[0]) |=> !ldo_discharge[0])
    else $error("discharge without request");

  // power good reaches the register after two edges
  pg_sync_a: assert property (@(posedge sys_clk) disable iff (rst)
    pg_two_edges_s |=> st_reg.pg_s2[1] == $past(pgood_pin[1], 2))
    else $error("power good not tracking pin");

  // a control write leaves power good to the synchroniser
  pg_wr_ignored_a: assert property (@(posedge sys_clk) disable iff (rst)
    (clk_en && wr_stb && chit[1]) |=> st_reg.pg_s2[1] == $past(st_reg.pg_s1[1]))
    else $error("power good taken from write data");

  // qualifying fault edge latches status, set over clear
  fault_set_a: assert property (@(posedge sys_clk) disable iff (rst)
    c_fault_edge_s |=> st_reg.sts[2])
    else $error("fault not latched");

  // write one to clear drops the status bit
  fault_clear_a: assert property (@(posedge sys_clk) disable iff (rst)
    (clk_en && wr_stb && addr == lrc_pkg::IRQ_CLEAR_OFS && wdata[2]
      && !(st_reg.ft_s2[2] && !st_reg.ft_d[2] && st_reg.fie[2])) |=> !st_reg.sts[2])
    else $error("status not cleared");

  // enabled status holds the interrupt line high
  irq_level_a: assert property (@(posedge sys_clk) disable iff (rst)
    (clk_en && !wr_stb && st_reg.sts[2] && st_reg.irq_en[2]) |=> irq)
    else $error("interrupt low with enabled status");

  // voltage read returns the stored code
  vsel_read_a: assert property (@(posedge sys_clk) disable iff (rst)
    (clk_en && rd_stb && vhit[2]) |=> rdata == {2'b00, $past(st_reg.vsel[2])})
    else $error("voltage read data wrong");

  // status read shows the sticky bits
  status_read_a: assert property (@(posedge sys_clk) disable iff (rst)
    (clk_en && rd_stb && addr == lrc_pkg::IRQ_STATUS_OFS)
      |=> rdata == {4'h0, $past(st_reg.sts)})
    else $error("status read data wrong");

  // unmapped read returns zero
  unmapped_rd_a: assert property (@(posedge sys_clk) disable iff (rst)
    (clk_en && rd_stb && vhit == 4'h0 && chit == 4'h0 && addr != lrc_pkg::IRQ_STATUS_OFS
      && addr != lrc_pkg::IRQ_ENABLE_OFS) |=> rdata == 8'h00)
    else $error("unmapped read not zero");

endmodule : lrc_regs
`default_nettype wire

// ---- tb/lrc_ldo_model.sv ----
`timescale 1ns/100ps
`default_nettype none
// regulator outputs seen by the bank: good two cycles after enable
module lrc_ldo_model (
  input wire logic sys_clk,
  input wire logic [3:0] ldo_on,
  input wire logic [3:0] fault_req,
  output logic [3:0] pgood_pin,
  output logic [3:0] fault_pin
);
  logic [3:0] ramp_reg;
  // output ramp, then power good
  always_ff @(posedge sys_clk)
  begin
    ramp_reg <= ldo_on;
    pgood_pin <= ramp_reg;
  end
  assign fault_pin = fault_req; // fault level from the bench
endmodule : lrc_ldo_model
`default_nettype wire

// ---- tb/tb_top.sv ----
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  logic sys_clk, rst, clk_en, wr_stb, rd_stb, irq;
  logic [7:0] addr, wdata, rdata;
  logic [3:0] pgood_pin, fault_pin, fault_req, ldo_on, ldo_discharge, ldo_low_quiescent_mode;
  logic [23:0] voltage_select_code;
  logic [7:0] vsel_ofs [4];
  int fail_count = 0;
  int checks_done = 0;
  lrc_regs uut (.sys_clk(sys_clk), .rst(rst), .clk_en(clk_en), .addr(addr), .wdata(wdata),
    .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata), .pgood_pin(pgood_pin),
    .fault_pin(fault_pin), .ldo_on(ldo_on), .ldo_discharge(ldo_discharge),
    .ldo_low_quiescent_mode(ldo_low_quiescent_mode), .voltage_select_code(voltage_select_code), .irq(irq));
  lrc_ldo_model far (.sys_clk(sys_clk), .ldo_on(ldo_on), .fault_req(fault_req),
    .pgood_pin(pgood_pin), .fault_pin(fault_pin));
  // free running clock
  initial
  begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end
  // compare and count
  task automatic check(input logic [23:0] seen, input logic [23:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  // one-cycle write strobe
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    addr <= a;
    wdata <= d;
    wr_stb <= 1'b1;
    @(posedge sys_clk);
    wr_stb <= 1'b0;
  endtask : wr
  // one-cycle read strobe, data checked in the following cycle
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge sys_clk);
    addr <= a;
    rd_stb <= 1'b1;
    @(posedge sys_clk);
    rd_stb <= 1'b0;
    @(negedge sys_clk);
    check(rdata, exp);
  endtask : rd
  // settle outputs before looking
  task automatic pause(input int n);
    repeat (n) @(negedge sys_clk);
  endtask : pause
  task automatic end_sim;
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : end_sim
  // hang guard, tests need about 1100 cycles
  initial
  begin
    repeat (20000) @(posedge sys_clk);
    fail_count++;
    end_sim();
  end
  // test sequence
  initial
  begin
    {rst, clk_en, wr_stb, rd_stb, addr, wdata, fault_req} = '1;
    {wr_stb, rd_stb, fault_req} = '0;
    vsel_ofs = '{lrc_pkg::LDO_A_VSEL_OFS, lrc_pkg::LDO_B_VSEL_OFS,
      lrc_pkg::LDO_C_VSEL_OFS, lrc_pkg::LDO_D_VSEL_OFS};
    repeat (5) @(posedge sys_clk);
    rst <= 1'b0;
    foreach (vsel_ofs[i])
    begin
      wr(vsel_ofs[i], 8'hFF);
      rd(vsel_ofs[i], 8'h3F);
    end
    check(voltage_select_code, 24'hFFFFFF);
    rd(8'h7F, 8'h00);
    // a write while the clock enable is low must leave the code alone
    @(posedge sys_clk);
    clk_en <= 1'b0;
    wr(lrc_pkg::LDO_C_VSEL_OFS, 8'h05);
    clk_en <= 1'b1;
    rd(lrc_pkg::LDO_C_VSEL_OFS, 8'h3F);
    $display("test voltage done");
    wr(lrc_pkg::LDO_A_CTRL_OFS, 8'hA1);
    pause(10);
    check({ldo_on, ldo_low_quiescent_mode, ldo_discharge}, 24'h110);
    rd(lrc_pkg::LDO_A_CTRL_OFS, 8'hA1);
    wr(lrc_pkg::LDO_A_CTRL_OFS, 8'h41);
    pause(10);
    check({ldo_on, ldo_low_quiescent_mode, ldo_discharge}, 24'h001);
    rd(lrc_pkg::LDO_A_CTRL_OFS, 8'h40);
    $display("test control done");
    wr(lrc_pkg::LDO_B_CTRL_OFS, 8'h84);
    pause(lrc_pkg::DLY_STEP_CYC - 10);
    check(ldo_on, 4'h0);
    pause(20);
    check(ldo_on, 4'h2);
    rd(lrc_pkg::LDO_B_CTRL_OFS, 8'h85);
    $display("test delay done");
    wr(lrc_pkg::IRQ_ENABLE_OFS, 8'h0F);
    wr(lrc_pkg::LDO_C_CTRL_OFS, 8'h02);
    wr(lrc_pkg::LDO_D_CTRL_OFS, 8'h00);
    @(posedge sys_clk);
    fault_req <= 4'hC;
    pause(10);
    check(irq, 1'b1);
    rd(lrc_pkg::IRQ_STATUS_OFS, 8'h04);
    @(posedge sys_clk);
    fault_req <= 4'h0;
    wr(lrc_pkg::IRQ_CLEAR_OFS, 8'h04);
    pause(4);
    check(irq, 1'b0);
    rd(lrc_pkg::IRQ_ENABLE_OFS, 8'h0F);
    $display("test fault done");
    // reset again in mid-run: everything back to zero
    @(posedge sys_clk);
    rst <= 1'b1;
    repeat (2) @(posedge sys_clk);
    rst <= 1'b0;
    rd(lrc_pkg::LDO_B_CTRL_OFS, 8'h00);
    check({ldo_on, ldo_discharge, voltage_select_code[15:0]}, 24'h000000);
    $display("test reset done");
    end_sim();
  end
endmodule : tb_top
`default_nettype wire
